// [rtl/adgcd_decoder.sv]
// serial command decoder for the converter, dac and gpio device
module adgcd_decoder
    import adgcd_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // serial pins
    input wire logic chipSelectN,
    input wire logic serialClock,
    input wire logic dataIn,
    output logic dataOut,
    // gpio pins, enable low while driving
    input wire logic [3:0] gpioIn,
    output logic [3:0] gpioOut,
    output logic [3:0] gpioOeN,
    // converter side configuration
    output adgcd_pair_e [3:0] pairMode,
    output adgcd_adc_cfg_t adcConfig,
    output logic fifoClear,
    // dac side word
    output logic dacWordValid,
    output adgcd_dac_word_t dacWord
);

    // timing budget: chip select and serial clock pass two flops and an edge compare, so the
    // decoder reacts about three clocks after a pin moves; the link clock must
    // therefore stay well below a quarter of the system clock
    // the slow tap can only add whole clocks, so the hold time extension is
    // rounded up rather than down and is never shorter than asked for
    // the delay line below is four taps long, enough for the default figures
    // slow mode delay in cycles, rounded up
    localparam int SLOW_CYC = (`ADGCD_SLOW_NS + `ADGCD_CLK_NS - 1) / `ADGCD_CLK_NS;

    adgcd_core_t state_q; // registered state
    adgcd_core_t state_d; // next state
    logic [`ADGCD_SYNC_W-1:0] pinRaw; // raw pin vector
    logic [`ADGCD_SYNC_W-1:0] pinSync; // synchronised pin vector
    logic csN; // synchronised chip select
    logic sclk; // synchronised serial clock
    logic din; // synchronised data in
    logic [3:0] gpioSync; // synchronised gpio levels
    logic sclkRise; // rising serial clock inside a frame
    logic sclkFall; // falling serial clock inside a frame
    logic csFall; // frame start
    logic csRise; // frame end
    logic [7:0] byteIn; // byte completed by this rising edge
    logic [15:0] wordIn; // word completed by this falling edge
    logic byteDone; // eighth bit of a byte taken

    // gpio levels ride through the same synchroniser as the serial pins
    // gather pins for the synchroniser
    assign pinRaw[`ADGCD_SYNC_CS] = chipSelectN;
    assign pinRaw[`ADGCD_SYNC_SCLK] = serialClock;
    assign pinRaw[`ADGCD_SYNC_DIN] = dataIn;
    assign pinRaw[`ADGCD_SYNC_GPIO_HI:`ADGCD_SYNC_GPIO_LO] = gpioIn;

    // every pin passes two flops before use
    adgcd_pin_sync u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .pinRaw(pinRaw),
        .pinSync(pinSync)
    );

    assign csN = pinSync[`ADGCD_SYNC_CS];
    assign sclk = pinSync[`ADGCD_SYNC_SCLK];
    assign din = pinSync[`ADGCD_SYNC_DIN];
    assign gpioSync = pinSync[`ADGCD_SYNC_GPIO_HI:`ADGCD_SYNC_GPIO_LO];

    // edge detection on the synchronised copies
    // serial clock edges count only while chip select is low, so a clock
    // that runs between frames shifts nothing
    assign csFall = state_q.csPrev & ~csN;
    assign csRise = ~state_q.csPrev & csN;
    assign sclkRise = ~csN & sclk & ~state_q.sclkPrev;
    assign sclkFall = ~csN & ~sclk & state_q.sclkPrev;
    assign byteIn = {state_q.shift[6:0], din};
    assign wordIn = {state_q.shift[14:0], din};
    assign byteDone = state_q.bitCnt == `ADGCD_BYTE_LAST;

    // one process holds the whole frame machine; chip select edges take
    // precedence over serial clock edges, so a frame that is cut short
    // always returns to the command state with its partial byte dropped
    // sequencer, registers and data out
    always_comb begin
        state_d = state_q;
        state_d.csPrev = csN;
        state_d.sclkPrev = sclk;
        state_d.fifoClear = 1'b0;
        state_d.dacValid = 1'b0;
        // data out delay line, tapped when slow
        state_d.doutDelay = {state_q.doutDelay[2:0], state_q.dout};
        state_d.doutPin = state_q.slow ? state_q.doutDelay[SLOW_CYC-1] : state_q.dout;

        if (csFall) begin
            // a new frame always opens with a command byte
            state_d.st = ST_COMMAND;
            state_d.bitCnt = 5'h00;
            state_d.dout = 1'b0;
        end else if (csRise) begin
            // held gpio data lands only now
            // a gpio byte cut short never set the hold flag, so nothing lands
            if (state_q.holdValid) begin
                if (state_q.holdIsCfg) begin
                    state_d.gpioCfg = state_q.gpioHold;
                end else begin
                    state_d.gpioWr = state_q.gpioHold;
                end
            end
            state_d.holdValid = 1'b0;
            // an unfinished dac word is dropped here
            state_d.st = ST_COMMAND;
            state_d.bitCnt = 5'h00;
            state_d.dout = 1'b0;
        end else if (sclkFall) begin
            unique case (state_q.st)
                ST_DAC_WORD: begin
                    // dac bits are taken on the falling edge
                    state_d.shift = wordIn;
                    state_d.bitCnt = state_q.bitCnt + 5'h01;
                    if (state_q.bitCnt == `ADGCD_WORD_LAST) begin
                        // control, data msb first, sub bits
                        state_d.dacWord = wordIn;
                        state_d.dacValid = 1'b1;
                        state_d.bitCnt = 5'h00;
                        state_d.st = ST_COMMAND;
                    end
                end
                ST_GPIO_READ: begin
                    // pin states move out msb first
                    state_d.dout = state_q.readShift[7];
                    state_d.readShift = {state_q.readShift[6:0], 1'b0};
                end
                default: begin
                    // command and write bytes answer with zero
                    state_d.dout = 1'b0;
                end
            endcase
        end else if (sclkRise && state_q.st != ST_DAC_WORD) begin
            state_d.shift = {state_q.shift[14:0], din};
            state_d.bitCnt = state_q.bitCnt + 5'h01;
            if (byteDone) begin
                state_d.bitCnt = 5'h00;
                state_d.st = ST_COMMAND;
                unique case (state_q.st)
                    ST_COMMAND: begin
                        if (byteIn[`ADGCD_CMD_CONV]) begin
                            // conversion byte: keep its scan mode
                            // its other fields belong to the converter side
                            state_d.scanMode = byteIn[`ADGCD_CONV_SCAN_HI:`ADGCD_CONV_SCAN_LO];
                        end else if (byteIn[`ADGCD_CMD_SETUP]) begin
                            state_d.setup = byteIn[`ADGCD_SETUP_W-1:0];
                            // only 10 and 11 are followed by a data byte
                            if (byteIn[`ADGCD_SETUP_PAIR_WR]) begin
                                state_d.st = ST_PAIR_DATA;
                            end else begin
                                state_d.st = ST_COMMAND;
                            end
                        end else if (byteIn[`ADGCD_CMD_AVG]) begin
                            // enable, average count, repeat count
                            state_d.avg = byteIn[`ADGCD_AVG_FIELD_HI:0];
                        end else if (byteIn[`ADGCD_CMD_DACSEL]) begin
                            // low nibble ignored, a word follows
                            state_d.st = ST_DAC_WORD;
                        end else if (byteIn[`ADGCD_CMD_RESET]) begin
                            // every reset register write empties the fifo
                            state_d.fifoClear = 1'b1;
                            if (byteIn[`ADGCD_RST_FULL]) begin
                                // defaults, but dac and gpio untouched
                                // slow output and forced bandgap drop back to off too
                                state_d.setup = `ADGCD_SETUP_RESET;
                                state_d.unipolar = 4'h0;
                                state_d.bipolar = 4'h0;
                                state_d.avg = '0;
                                state_d.scanMode = 2'h0;
                                state_d.slow = 1'b0;
                                state_d.fbg = 1'b0;
                            end else begin
                                state_d.slow = byteIn[`ADGCD_RST_SLOW];
                                state_d.fbg = byteIn[`ADGCD_RST_FBG];
                            end
                        end else if (byteIn[`ADGCD_GPIO_RSVD]) begin
                            // not a decoded gpio command, ignored
                            state_d.st = ST_COMMAND;
                        end else begin
                            unique case (byteIn[`ADGCD_GPIO_SEL_HI:0])
                                `ADGCD_GPIO_CFG: begin
                                    state_d.st = ST_GPIO_DATA;
                                    state_d.holdIsCfg = 1'b1;
                                end
                                `ADGCD_GPIO_WR: begin
                                    state_d.st = ST_GPIO_DATA;
                                    state_d.holdIsCfg = 1'b0;
                                end
                                `ADGCD_GPIO_RD: begin
                                    // four zeros, then C1 C0 A1 A0
                                    state_d.st = ST_GPIO_READ;
                                    state_d.readShift = {4'h0, gpioSync};
                                end
                                default: begin
                                    state_d.st = ST_COMMAND;
                                end
                            endcase
                        end
                    end
                    ST_PAIR_DATA: begin
                        // upper nibble holds the four pairs
                        if (state_q.setup[`ADGCD_SETUP_PAIR_BI]) begin
                            state_d.bipolar = byteIn[`ADGCD_NIB_HI:`ADGCD_NIB_LO];
                        end else begin
                            state_d.unipolar = byteIn[`ADGCD_NIB_HI:`ADGCD_NIB_LO];
                        end
                    end
                    ST_GPIO_DATA: begin
                        // holding stage, low nibble ignored
                        state_d.gpioHold = byteIn[`ADGCD_NIB_HI:`ADGCD_NIB_LO];
                        state_d.holdValid = 1'b1;
                    end
                    ST_GPIO_READ: begin
                        // eight read clocks over
                        state_d.st = ST_COMMAND;
                    end
                    ST_DAC_WORD: begin
                        // not reached on rising edges
                        state_d.st = ST_DAC_WORD;
                    end
                endcase
            end
        end
    end

    // the edge detectors start at the idle levels of their pins, chip select
    // high and serial clock low, so no false edge follows reset
    // power-up defaults
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '{
                st: ST_COMMAND,
                bitCnt: 5'h00,
                shift: 16'h0000,
                csPrev: 1'b1,
                sclkPrev: 1'b0,
                setup: `ADGCD_SETUP_RESET,
                unipolar: 4'h0,
                bipolar: 4'h0,
                avg: 5'h00,
                scanMode: 2'h0,
                slow: 1'b0,
                fbg: 1'b0,
                gpioCfg: 4'h0,
                gpioWr: 4'hf,
                gpioHold: 4'h0,
                holdValid: 1'b0,
                holdIsCfg: 1'b0,
                readShift: 8'h00,
                dout: 1'b0,
                doutDelay: 4'h0,
                doutPin: 1'b0,
                fifoClear: 1'b0,
                dacValid: 1'b0,
                dacWord: 16'h0000
            };
        end else begin
            state_q <= state_d;
        end
    end

    // everything below is a plain decode of registered state, so the
    // converter side sees stable levels between register writes
    // channel pair function, one per pair
    for (genvar p = 0; p < 4; p++) begin : g_pair
        // register bit 7 is pair 0, bit 4 is pair 3
        assign pairMode[p] = state_q.unipolar[3-p] ? PAIR_UNI_DIFF :
                             state_q.bipolar[3-p] ? PAIR_BI_DIFF : PAIR_UNI_SINGLE;
        // bipolar pairs return two's complement
        assign adcConfig.twosComplement[p] = ~state_q.unipolar[3-p] & state_q.bipolar[3-p];
    end

    // setup fields
    assign adcConfig.clockSelect = state_q.setup[`ADGCD_SETUP_CLK_HI:`ADGCD_SETUP_CLK_LO];
    assign adcConfig.referenceSelect = state_q.setup[`ADGCD_SETUP_REF_HI:`ADGCD_SETUP_REF_LO];
    assign adcConfig.scanMode = state_q.scanMode;

    // averaging off in clock mode 11
    assign adcConfig.averagingActive = state_q.avg.average_enable &
        (adcConfig.clockSelect != `ADGCD_CLK_MODE_NOAVG);
    assign adcConfig.conversionsPerResult = adcConfig.averagingActive ?
        (`ADGCD_AVG_MIN << state_q.avg.averageCount) : 6'h01;

    // repeat count only in scan mode 10
    assign adcConfig.resultsPerScan = (state_q.scanMode == `ADGCD_SCAN_REPEAT) ?
        5'(`ADGCD_REPEAT_STEP * (state_q.avg.repeatCount + 5'h01)) : 5'h01;

    // bandgap forcing and slow output
    assign adcConfig.forceBandgapOn = state_q.fbg;
    assign adcConfig.skipWakeDelay = state_q.fbg &
        adcConfig.clockSelect[0] & (adcConfig.clockSelect[1] |
        (adcConfig.clockSelect == `ADGCD_CLK_MODE_WAKE));
    assign adcConfig.slowMode = state_q.slow;

    // the pin stage adds one register, so pins move one clock after the
    // configure or write register is committed
    // gpio pin drivers
    adgcd_gpio_port u_gpio (
        .clock(clock),
        .reset_n(reset_n),
        .configBits(state_q.gpioCfg),
        .writeBits(state_q.gpioWr),
        .gpioOut(gpioOut),
        .gpioOeN(gpioOeN)
    );

    // every output below comes straight from a flip-flop
    // registered outputs
    assign dataOut = state_q.doutPin;
    assign fifoClear = state_q.fifoClear;
    assign dacWordValid = state_q.dacValid;
    assign dacWord = state_q.dacWord;

endmodule // adgcd_decoder

// [shared/adgcd_map.svh]
// constants of the serial command decoder: pin slots, command bits, field positions, timing
`ifndef ADGCD_MAP_SVH
`define ADGCD_MAP_SVH

// slots in the synchronised pin vector
`define ADGCD_SYNC_W 7
`define ADGCD_SYNC_CS 0
`define ADGCD_SYNC_SCLK 1
`define ADGCD_SYNC_DIN 2
`define ADGCD_SYNC_GPIO_LO 3
`define ADGCD_SYNC_GPIO_HI 6
`define ADGCD_SYNC_IDLE 7'h01

// timing
`define ADGCD_CLK_NS 4
`define ADGCD_SLOW_NS 15

// command class bits, highest set bit wins
`define ADGCD_CMD_CONV 7
`define ADGCD_CMD_SETUP 6
`define ADGCD_CMD_AVG 5
`define ADGCD_CMD_DACSEL 4
`define ADGCD_CMD_RESET 3

// reset register bits
`define ADGCD_RST_FULL 2
`define ADGCD_RST_SLOW 1
`define ADGCD_RST_FBG 0

// setup byte fields
`define ADGCD_SETUP_W 6
`define ADGCD_SETUP_RESET 6'h28
`define ADGCD_SETUP_CLK_HI 5
`define ADGCD_SETUP_CLK_LO 4
`define ADGCD_SETUP_REF_HI 3
`define ADGCD_SETUP_REF_LO 2
`define ADGCD_SETUP_PAIR_WR 1
`define ADGCD_SETUP_PAIR_BI 0

// conversion byte scan field
`define ADGCD_CONV_SCAN_HI 2
`define ADGCD_CONV_SCAN_LO 1

// averaging byte and gpio command fields
`define ADGCD_AVG_FIELD_HI 4
`define ADGCD_GPIO_RSVD 2
`define ADGCD_GPIO_SEL_HI 1

// field codes
`define ADGCD_CLK_MODE_NOAVG 2'h3
`define ADGCD_CLK_MODE_WAKE 2'h1
`define ADGCD_SCAN_REPEAT 2'h2
`define ADGCD_GPIO_CFG 2'h3
`define ADGCD_GPIO_WR 2'h2
`define ADGCD_GPIO_RD 2'h1

// counts
`define ADGCD_BYTE_LAST 5'h07
`define ADGCD_WORD_LAST 5'h0f
`define ADGCD_AVG_MIN 6'h04
`define ADGCD_REPEAT_STEP 5'h04
`define ADGCD_NIB_HI 7
`define ADGCD_NIB_LO 4

`endif

// [shared/adgcd_pkg.sv]
// types of the serial command decoder
`include "adgcd_map.svh"
package adgcd_pkg;

    // serial sequencer states
    typedef enum logic [2:0] {
        ST_COMMAND, ST_PAIR_DATA, ST_GPIO_DATA, ST_GPIO_READ, ST_DAC_WORD
    } adgcd_state_e;

    // channel pair function
    typedef enum logic [1:0] {
        PAIR_UNI_SINGLE, PAIR_BI_DIFF, PAIR_UNI_DIFF
    } adgcd_pair_e;

    // two-stage synchroniser contents
    typedef struct packed {
        logic [`ADGCD_SYNC_W-1:0] first;
        logic [`ADGCD_SYNC_W-1:0] second;
    } adgcd_sync_t;

    // averaging register contents
    typedef struct packed {
        logic average_enable;
        logic [1:0] averageCount;
        logic [1:0] repeatCount;
    } adgcd_avg_t;

    // captured dac word
    typedef struct packed {
        logic [3:0] control;
        logic [9:0] data;
        logic [1:0] sub;
    } adgcd_dac_word_t;

    // configuration handed to the converter side
    typedef struct packed {
        logic [1:0] clockSelect;
        logic [1:0] referenceSelect;
        logic [1:0] scanMode;
        logic [5:0] conversionsPerResult;
        logic [4:0] resultsPerScan;
        logic averagingActive;
        logic [3:0] twosComplement;
        logic forceBandgapOn;
        logic skipWakeDelay;
        logic slowMode;
    } adgcd_adc_cfg_t;

    // gpio pin driver state
    typedef struct packed {
        logic [3:0] pinOut;
        logic [3:0] pinOeN;
    } adgcd_gpio_t;

    // whole decoder state
    typedef struct packed {
        adgcd_state_e st;
        logic [4:0] bitCnt;
        logic [15:0] shift;
        logic csPrev;
        logic sclkPrev;
        logic [`ADGCD_SETUP_W-1:0] setup;
        logic [3:0] unipolar;
        logic [3:0] bipolar;
        adgcd_avg_t avg;
        logic [1:0] scanMode;
        logic slow;
        logic fbg;
        logic [3:0] gpioCfg;
        logic [3:0] gpioWr;
        logic [3:0] gpioHold;
        logic holdValid;
        logic holdIsCfg;
        logic [7:0] readShift;
        logic dout;
        logic [3:0] doutDelay;
        logic doutPin;
        logic fifoClear;
        logic dacValid;
        adgcd_dac_word_t dacWord;
    } adgcd_core_t;

endpackage

// [rtl/adgcd_pin_sync.sv]
// two flip-flop synchroniser for every pin that enters from outside the clock
module adgcd_pin_sync
    import adgcd_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // raw pins and their synchronised copies
    input wire logic [`ADGCD_SYNC_W-1:0] pinRaw,
    output logic [`ADGCD_SYNC_W-1:0] pinSync
);

    adgcd_sync_t state_q; // both stages
    adgcd_sync_t state_d; // next stages

    // first stage feeds only the second stage
    always_comb begin
        state_d = state_q;
        state_d.first = pinRaw;
        state_d.second = state_q.first;
    end

    // chip select idles high, everything else low
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '{first: `ADGCD_SYNC_IDLE, second: `ADGCD_SYNC_IDLE};
        end else begin
            state_q <= state_d;
        end
    end

    assign pinSync = state_q.second;

endmodule // adgcd_pin_sync

// [rtl/adgcd_gpio_port.sv]
// gpio pin drivers: push-pull output, input, or open-drain pull low
module adgcd_gpio_port
    import adgcd_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // register contents
    input wire logic [3:0] configBits,
    input wire logic [3:0] writeBits,
    // pin drive, enable low while driving
    output logic [3:0] gpioOut,
    output logic [3:0] gpioOeN
);

    adgcd_gpio_t state_q; // registered drive
    adgcd_gpio_t state_d; // next drive

    // per pin mode decode
    always_comb begin
        state_d = state_q;
        for (int i = 0; i < 4; i++) begin
            if (configBits[i]) begin
                // output follows the write bit
                state_d.pinOut[i] = writeBits[i];
                state_d.pinOeN[i] = 1'b0;
            end else if (writeBits[i]) begin
                // released, pin is an input
                state_d.pinOut[i] = 1'b0;
                state_d.pinOeN[i] = 1'b1;
            end else begin
                // open-drain pull low
                state_d.pinOut[i] = 1'b0;
                state_d.pinOeN[i] = 1'b0;
            end
        end
    end

    // all pins released at power-up
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '{pinOut: 4'h0, pinOeN: 4'hf};
        end else begin
            state_q <= state_d;
        end
    end

    assign gpioOut = state_q.pinOut;
    assign gpioOeN = state_q.pinOeN;

endmodule // adgcd_gpio_port

// [tb/adgcd_decoder_asserts.sv]
// port relations of the serial command decoder
module adgcd_checker
    import adgcd_pkg::*;
(
    // clock, reset and pins
    input wire logic clock,
    input wire logic reset_n,
    input wire logic chipSelectN,
    input wire logic [3:0] gpioOeN,
    // converter and dac side
    input wire adgcd_pair_e [3:0] pairMode,
    input wire adgcd_adc_cfg_t adcConfig,
    input wire logic fifoClear,
    input wire logic dacWordValid,
    input wire adgcd_dac_word_t dacWord
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    logic [3:0] biPairs; // pairs decoded as bipolar
    // mark every bipolar pair
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            biPairs[i] = pairMode[i] == PAIR_BI_DIFF;
        end
    end
    // chip select high now and two cycles back
    sequence csSettled;
        chipSelectN && $past(chipSelectN, 2);
    endsequence
    a_format_by_pair: assert property (adcConfig.twosComplement == biPairs)
        else $error("result format differs from pair mode");
    a_start_pairs: assert property ($rose(reset_n) |-> pairMode == 8'h00)
        else $error("pairs not single ended after reset");
    a_start_setup: assert property ($rose(reset_n) |-> adcConfig.clockSelect == 2'h2)
        else $error("clock mode not 10 after reset");
    a_pins_input: assert property ($rose(reset_n) |-> gpioOeN == 4'hf)
        else $error("pins not inputs after reset");
    a_clk_no_avg: assert property (adcConfig.clockSelect == 2'h3
        |-> !adcConfig.averagingActive)
        else $error("averaging active in clock mode 11");
    a_single_conv: assert property (!adcConfig.averagingActive
        |-> adcConfig.conversionsPerResult == 6'h01)
        else $error("more than one conversion without averaging");
    a_scan_single: assert property (adcConfig.scanMode != 2'h2
        |-> adcConfig.resultsPerScan == 5'h01)
        else $error("repeat count outside scan mode 10");
    a_wake_skip: assert property (adcConfig.skipWakeDelay
        == (adcConfig.forceBandgapOn && adcConfig.clockSelect[0]))
        else $error("wake delay skip mismatch");
    a_pin_commit: assert property (gpioOeN != $past(gpioOeN) |-> csSettled)
        else $error("pin change while chip select low");
    a_fifo_pulse: assert property (fifoClear |=> !fifoClear)
        else $error("fifo clear longer than one cycle");
    a_dac_hold: assert property (!dacWordValid |-> $stable(dacWord))
        else $error("dac word changed without valid");
endmodule // adgcd_checker

bind adgcd_decoder adgcd_checker chk (.clock, .reset_n, .chipSelectN, .gpioOeN, .pairMode,
    .adcConfig, .fifoClear, .dacWordValid, .dacWord);

// [tb/adgcd_host.sv]
// host side serial master: frames, released lines, data out capture
module adgcd_host
    import adgcd_pkg::*;
(
    // bench clock that paces the link
    input wire logic clock,
    // serial pins
    output logic csN,
    output logic sclk,
    output logic din,
    input wire logic dout
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int QUARTER = 10; // a quarter of the 160 ns link period, in clocks
    logic [31:0] rx; // data out taken on rising edges
    // idle: deselected, clock still
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end
    // msb first; data moves mid-high so falling-edge bits are steady
    task automatic frame(input logic [31:0] v, input int n, input int cyc);
        @(posedge clock);
        csN <= 1'b0;
        din <= v[n-1];
        rx = '0;
        for (int i = 0; i < cyc; i++) begin
            repeat (2 * QUARTER) @(posedge clock);
            sclk <= 1'b1;
            rx = {rx[30:0], dout};
            repeat (QUARTER) @(posedge clock);
            din <= (i + 2 > n) ? ~din : v[n-2-i];
            repeat (QUARTER) @(posedge clock);
            sclk <= 1'b0;
        end
    endtask
    // end the frame and let the data line wander
    task automatic close();
        repeat (2 * QUARTER) @(posedge clock);
        csN <= 1'b1;
        din <= ~din;
    endtask
endmodule // adgcd_host

// [tb/test_adc_dac_gpio_cmd_decoder.sv]
// self-checking bench of the serial command decoder
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", n, e, a); end end
module test_adc_dac_gpio_cmd_decoder
    import adgcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic csN, sclk, din, dout, fc, dv;
    logic [3:0] pull = 4'h5; // outside levels on released pins
    logic [3:0] gIn, gOut, gOeN;
    adgcd_pair_e [3:0] pm;
    adgcd_adc_cfg_t cfg;
    adgcd_dac_word_t dw;
    int fail_count = 0;
    int num_checks = 0;
    int fcs = 0; // fifo clear pulses
    int dvs = 0; // dac word pulses
    assign gIn = (gOeN & pull) | (~gOeN & gOut); // pin level from both sides
    initial begin
        forever #2 clock = ~clock;
    end
    // count one-cycle pulses
    always @(posedge clock) begin
        fcs <= fcs + fc;
        dvs <= dvs + dv;
    end
    adgcd_decoder dut (.clock, .reset_n, .chipSelectN(csN), .serialClock(sclk), .dataIn(din),
        .dataOut(dout), .gpioIn(gIn), .gpioOut(gOut), .gpioOeN(gOeN), .pairMode(pm),
        .adcConfig(cfg), .fifoClear(fc), .dacWordValid(dv), .dacWord(dw));
    adgcd_host host (.clock, .csN, .sclk, .din, .dout);
    // one whole frame, then let the decoder settle
    task automatic send(input logic [31:0] v, input int n, input int cyc = 0);
        host.frame(v, n, (cyc != 0) ? cyc : n);
        host.close();
        repeat (12) @(posedge clock);
    endtask
    // counts, verdict and end of run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clock);
        reset_n <= 1'b1;
        repeat (4) @(posedge clock);
        `CHK("pairs", 8'h00, pm)
        `CHK("clock mode", 2'h2, cfg.clockSelect)
        `CHK("reference", 2'h2, cfg.referenceSelect)
        `CHK("pin enables", 4'hf, gOeN)
        send(32'h6aa0, 16);
        send(32'h6bc0, 16);
        `CHK("pairs", 8'h26, pm)
        `CHK("format", 4'h2, cfg.twosComplement)
        send(32'h6933, 16);
        `CHK("pairs", 8'h26, pm)
        `CHK("conversions", 6'h04, cfg.conversionsPerResult)
        send(32'h0084, 8);
        `CHK("scan mode", 2'h2, cfg.scanMode)
        for (int k = 0; k < 4; k++) begin
            send(32'h30 | (k * 5), 8);
            `CHK("conversions", 6'h04 << k, cfg.conversionsPerResult)
            `CHK("results", 5'h04 * (k + 1), cfg.resultsPerScan)
        end
        send(32'h2c, 8);
        `CHK("conversions", 6'h01, cfg.conversionsPerResult)
        send(32'h3070, 16);
        `CHK("averaging", 1'b0, cfg.averagingActive)
        send(32'h0b, 8);
        `CHK("slow", 1'b1, cfg.slowMode)
        `CHK("bandgap", 1'b1, cfg.forceBandgapOn)
        `CHK("wake skip", 1'b1, cfg.skipWakeDelay)
        `CHK("fifo pulses", 1, fcs)
        send(32'h03a0, 16);
        `CHK("data out", 16'h0000, host.rx[15:0])
        `CHK("pin enables", 4'h5, gOeN)
        host.frame(32'h0290, 16, 16);
        repeat (12) @(posedge clock);
        `CHK("pin enables", 4'h5, gOeN)
        host.close();
        repeat (12) @(posedge clock);
        `CHK("pin enables", 4'h1, gOeN)
        `CHK("pin drive", 4'h8, gOut & ~gOeN)
        send(32'h0400, 16);
        `CHK("pin enables", 4'h1, gOeN)
        send(32'h0100, 16);
        `CHK("pin read", 16'h0009, host.rx[15:0])
        send({8'h1f, 16'hf034}, 24, 23);
        `CHK("dac word", 16'hf034, dw)
        send({8'h10, 16'h1234}, 24, 12);
        `CHK("dac pulses", 1, dvs)
        send(32'h0c, 8);
        `CHK("pairs", 8'h00, pm)
        `CHK("clock mode", 2'h2, cfg.clockSelect)
        `CHK("slow", 1'b0, cfg.slowMode)
        `CHK("bandgap", 1'b0, cfg.forceBandgapOn)
        `CHK("pin enables", 4'h1, gOeN)
        `CHK("dac word", 16'hf034, dw)
        `CHK("fifo pulses", 2, fcs)
        give_verdict();
    end
endmodule // test_adc_dac_gpio_cmd_decoder
